// ### logic/mfps_sequencer.sv
// Operation
// - four phases form one instruction cycle
// - first phase increments counter and fetches
// - decode and execute in phases two-four
// - fetch overlaps execute, one-cycle throughput
// - counter-changing instructions take two cycles
// - sequential flow advances counter by one
// - counter width follows program memory size
// - only low counter byte is software-visible
// - low byte write jumps in page, dummy
// - taken skip discards prefetch, dummy cycle
// - branch, call, interrupt, reset load target
// - return stack hidden, holds counter only
// - call or interrupt acknowledge pushes counter
// - both returns pop stack into counter
// - reset points stack index at top
// - full stack defers interrupt until return
// - call on full stack still overflows
// - alu writes destination and updates status
// - add, subtract, decimal adjust, logic ops
// - rotates, increment, decrement to either destination
// - reset starts fetch at reset vector
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module mfps_sequencer
  import mfps_pkg::*;
#(
  parameter int          PC_W         = PC_W_DEFAULT,
  parameter int          STACK_DEPTH  = STACK_DEPTH_DEF,
  parameter logic [11:0] RESET_VECTOR = RESET_VECTOR_DEF,
  parameter logic [11:0] INT_VECTOR   = INT_VECTOR_DEF
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire mfps_reg_req_type regReq,
  output      logic [7:0]       regRdData,
  output      logic [PC_W-1:0]  pmAddr,
  input  wire logic [INSTR_W-1:0] pmData,
  output      mfps_dmem_type    dmem,
  input  wire logic [7:0]       dmemRdData,
  input  wire logic             intRequest,
  output      logic             intAck,
  output      mfps_phase_type   instructionPhases
);

  localparam int SI_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SI_W-1:0] SI_DEPTH = SI_W'(STACK_DEPTH);
  localparam logic [SI_W-1:0] SI_ONE   = SI_W'(1);
  localparam logic [SI_W-1:0] SI_ZERO  = '0;
  localparam logic [PC_W-1:0] PC_ONE   = PC_W'(1);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic mfps_op_type opOf(input logic [INSTR_W-1:0] instr);
    opOf = mfps_op_type'(instr[OP_MSB:OP_LSB]);
  endfunction

  function automatic mfps_alu_type addCore(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic [3:0] st);
    logic [8:0] sum;
    logic [4:0] half;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    addCore.result = sum[7:0];
    addCore.status = st;
    addCore.status[ST_C] = sum[8];
    addCore.status[ST_AC] = half[4];
    addCore.status[ST_Z] = (sum[7:0] == BYTE_ZERO);
    addCore.status[ST_OV] = (a[BYTE_MSB] == b[BYTE_MSB]) && (sum[BYTE_MSB] != a[BYTE_MSB]);
  endfunction

  function automatic mfps_alu_type aluRun(input mfps_op_type op, input logic [7:0] a,
                                          input logic [7:0] m, input logic [3:0] st);
    logic [7:0] adj;
    logic       carryOut;
    aluRun.result = m;
    aluRun.status = st;
    adj = BYTE_ZERO;
    carryOut = st[ST_C];
    case (op)
      OP_ADD: aluRun = addCore(a, m, 1'b0, st);
      OP_ADC: aluRun = addCore(a, m, st[ST_C], st);
      OP_SUB: aluRun = addCore(a, ~m, 1'b1, st);
      OP_SBC: aluRun = addCore(a, ~m, st[ST_C], st);
      OP_DECIMAL_ADJUST: begin
        if ((a[3:0] > BCD_MAX) || st[ST_AC]) begin
          adj = adj | BCD_LOW;
        end
        if ((a[7:4] > BCD_MAX) || st[ST_C]) begin
          adj = adj | BCD_HIGH;
        end
        aluRun = addCore(a, adj, 1'b0, st);
        carryOut = st[ST_C] | aluRun.status[ST_C];
        aluRun.status = st;
        aluRun.status[ST_C] = carryOut;
      end
      OP_AND: aluRun.result = a & m;
      OP_OR:  aluRun.result = a | m;
      OP_XOR: aluRun.result = a ^ m;
      OP_CPL: aluRun.result = ~m;
      OP_RR:  aluRun.result = {m[0], m[7:1]};
      OP_RL:  aluRun.result = {m[6:0], m[7]};
      OP_RRC: begin
        aluRun.result = {st[ST_C], m[7:1]};
        carryOut = m[0];
      end
      OP_RLC: begin
        aluRun.result = {m[6:0], st[ST_C]};
        carryOut = m[7];
      end
      OP_INC, OP_SIZ: aluRun.result = m + BYTE_ONE;
      OP_DEC, OP_SDZ: aluRun.result = m - BYTE_ONE;
      OP_STA: aluRun.result = a;
      default: aluRun.result = m;
    endcase
    if (op == OP_RRC || op == OP_RLC) begin
      aluRun.status[ST_C] = carryOut;
    end
    if (op inside {OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC}) begin
      aluRun.status[ST_Z] = (aluRun.result == BYTE_ZERO);
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [PC_W-1:0]    pc;
  logic [INSTR_W-1:0] prefetch;
  logic [INSTR_W-1:0] execInstr;
  logic               execValid;
  logic               flushPending;
  logic [7:0]         acc;
  logic [3:0]         status;
  logic [7:0]         memOperand;
  logic [SI_W-1:0]    stackIndex;
  logic [PC_W-1:0]    stackMem [STACK_DEPTH];
  logic               stackOverflow;
  logic               intPending;

  // ****************************************************************
  // decode and control
  // ****************************************************************
  mfps_op_type     op;
  mfps_alu_type    alu;
  logic            atExec;
  logic            toMem;
  logic            isBranch;
  logic            isCall;
  logic            isReturn;
  logic            isSkipOp;
  logic            skipTaken;
  logic            stackFull;
  logic            intTake;
  logic            pclWrite;
  logic            doPush;
  logic            pcLoad;
  logic [PC_W-1:0] pushValue;
  logic [PC_W-1:0] loadTarget;
  logic [PC_W-1:0] stackTop;
  logic            writesMem;
  logic            writesAcc;

  assign op        = opOf(execInstr);
  assign toMem     = execInstr[TO_MEM_BIT];
  assign atExec    = (instructionPhases == PH_EXECUTE) && execValid;
  assign alu       = aluRun(op, acc, memOperand, status);
  assign isCall    = atExec && (op == OP_CALL);
  assign isReturn  = atExec && (op inside {OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN});
  assign isBranch  = isCall || isReturn || (atExec && op == OP_UNCONDITIONAL_BRANCH);
  assign isSkipOp  = op inside {OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ};
  assign stackFull = (stackIndex == SI_DEPTH);
  assign pclWrite  = regReq.wr && (regReq.addr == REG_PC_LOW_BYTE);
  assign stackTop  = (stackIndex == SI_ZERO) ? stackMem[0] : stackMem[stackIndex - SI_ONE];
  assign writesMem = atExec && ((toMem && !isSkipOp && op != OP_LDA && op != OP_NOP &&
                     op < OP_UNCONDITIONAL_BRANCH) || op == OP_STA ||
                     ((op == OP_SIZ || op == OP_SDZ) && toMem));
  assign writesAcc = atExec && !toMem && op != OP_NOP && op != OP_STA &&
                     op != OP_SZ && op != OP_SNZ && op < OP_UNCONDITIONAL_BRANCH;

  always_comb begin
    case (op)
      OP_SZ:   skipTaken = atExec && (memOperand == BYTE_ZERO);
      OP_SNZ:  skipTaken = atExec && (memOperand != BYTE_ZERO);
      OP_SIZ,
      OP_SDZ:  skipTaken = atExec && (alu.result == BYTE_ZERO);
      default: skipTaken = 1'b0;
    endcase
  end

  // a full stack holds the request back; the prefetched word is refetched after return
  assign intTake    = (instructionPhases == PH_EXECUTE) && intPending && !stackFull &&
                      !isBranch && !skipTaken && !flushPending && !pclWrite;
  assign doPush     = isCall || intTake;
  // the counter runs one word ahead; the flushed prefetch is where execution resumes
  assign pushValue  = pc - PC_ONE;
  assign pcLoad     = isBranch || intTake;
  always_comb begin
    if (isReturn) begin
      loadTarget = stackTop;
    end else if (intTake) begin
      loadTarget = INT_VECTOR[PC_W-1:0];
    end else begin
      loadTarget = execInstr[PC_W-1:0];
    end
  end

  // ****************************************************************
  // phase sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instructionPhases <= PH_FETCH;
    end else begin
      case (instructionPhases)
        PH_FETCH:   instructionPhases <= PH_DECODE;
        PH_DECODE:  instructionPhases <= PH_OPERAND;
        PH_OPERAND: instructionPhases <= PH_EXECUTE;
        PH_EXECUTE: instructionPhases <= PH_FETCH;
        default:    instructionPhases <= PH_FETCH;
      endcase
    end
  end

  // ****************************************************************
  // program counter and fetch pipeline
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc <= RESET_VECTOR[PC_W-1:0];
    end else if (pclWrite) begin
      pc <= {pc[PC_W-1:PC_LOW_W], regReq.wrData};
    end else if (pcLoad) begin
      pc <= loadTarget;
    end else if (instructionPhases == PH_FETCH) begin
      pc <= pc + PC_ONE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pmAddr    <= '0;
      prefetch  <= '0;
      execInstr <= '0;
      execValid <= 1'b0;
    end else begin
      if (instructionPhases == PH_FETCH) begin
        pmAddr    <= pc;
        execInstr <= prefetch;
        execValid <= !flushPending;
      end
      if (instructionPhases == PH_DECODE) begin
        prefetch <= pmData;
      end
    end
  end

  // a new flush request wins over the clear at the cycle boundary
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flushPending <= 1'b1;
    end else if (pcLoad || skipTaken || pclWrite) begin
      flushPending <= 1'b1;
    end else if (instructionPhases == PH_FETCH) begin
      flushPending <= 1'b0;
    end
  end

  // ****************************************************************
  // return stack
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stackIndex <= SI_ZERO;
    end else if (doPush && !stackFull) begin
      stackIndex <= stackIndex + SI_ONE;
    end else if (isReturn && stackIndex != SI_ZERO) begin
      stackIndex <= stackIndex - SI_ONE;
    end
  end

  // no reset on the storage itself; only the index gives it meaning
  always_ff @(posedge clk) begin
    if (doPush) begin
      if (stackFull) begin
        stackMem[STACK_DEPTH-1] <= pushValue;
      end else begin
        stackMem[stackIndex] <= pushValue;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stackOverflow <= 1'b0;
    end else if (isCall && stackFull) begin
      stackOverflow <= 1'b1;
    end else if (regReq.wr && regReq.addr == REG_STACK_STATE &&
                 regReq.wrData[SS_OVERFLOW_BIT]) begin
      stackOverflow <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt deferral
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intPending <= 1'b0;
      intAck     <= 1'b0;
    end else begin
      intAck <= intTake;
      if (intRequest) begin
        intPending <= 1'b1;
      end else if (intTake) begin
        intPending <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // alu and data memory
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc    <= BYTE_ZERO;
      status <= ST_RESET;
    end else if (atExec && op < OP_UNCONDITIONAL_BRANCH) begin
      if (writesAcc) begin
        acc <= alu.result;
      end
      status <= alu.status;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dmem       <= '0;
      memOperand <= BYTE_ZERO;
    end else begin
      dmem.wrEn <= writesMem;
      if (instructionPhases == PH_DECODE) begin
        dmem.addr <= execInstr[BYTE_MSB:0];
      end
      if (instructionPhases == PH_OPERAND) begin
        memOperand <= dmemRdData;
      end
      if (writesMem) begin
        dmem.wrData <= alu.result;
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= BYTE_ZERO;
    end else if (regReq.rd) begin
      case (regReq.addr)
        REG_PC_LOW_BYTE: regRdData <= pc[PC_LOW_W-1:0];
        REG_STATUS:      regRdData <= {4'h0, status};
        REG_ACCUMULATOR: regRdData <= acc;
        REG_STACK_STATE: regRdData <= {5'h00, intPending, stackOverflow, stackFull};
        default:         regRdData <= BYTE_ZERO;
      endcase
    end else begin
      regRdData <= BYTE_ZERO;
    end
  end

endmodule

// ### logic/mfps_pkg.sv
package mfps_pkg;

  // ****************************************************************
  // widths and variants
  // ****************************************************************
  localparam int PC_W_DEFAULT     = 12;
  localparam int STACK_DEPTH_DEF  = 6;
  localparam int INSTR_W          = 20;
  localparam int OP_MSB           = 19;
  localparam int OP_LSB           = 15;
  localparam int TO_MEM_BIT       = 14;
  localparam int BYTE_MSB         = 7;
  localparam int PC_LOW_W         = 8;

  // ****************************************************************
  // vectors
  // ****************************************************************
  localparam logic [11:0] RESET_VECTOR_DEF = 12'h000;
  localparam logic [11:0] INT_VECTOR_DEF   = 12'h004;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_PC_LOW_BYTE  = 8'h00;
  localparam logic [7:0] REG_STATUS       = 8'h01;
  localparam logic [7:0] REG_ACCUMULATOR  = 8'h02;
  localparam logic [7:0] REG_STACK_STATE  = 8'h03;
  localparam int         SS_FULL_BIT      = 0;
  localparam int         SS_OVERFLOW_BIT  = 1;
  localparam int         SS_INT_PEND_BIT  = 2;

  // ****************************************************************
  // status flags and alu constants
  // ****************************************************************
  localparam int         ST_C    = 0;
  localparam int         ST_AC   = 1;
  localparam int         ST_Z    = 2;
  localparam int         ST_OV   = 3;
  localparam logic [3:0] ST_RESET = 4'h0;
  localparam logic [3:0] BCD_MAX  = 4'h9;
  localparam logic [7:0] BCD_LOW  = 8'h06;
  localparam logic [7:0] BCD_HIGH = 8'h60;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    PH_FETCH,
    PH_DECODE,
    PH_OPERAND,
    PH_EXECUTE
  } mfps_phase_type;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DECIMAL_ADJUST,
    OP_AND, OP_OR, OP_XOR, OP_CPL, OP_RR, OP_RRC, OP_RL, OP_RLC,
    OP_INC, OP_DEC, OP_LDA, OP_STA, OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ,
    OP_UNCONDITIONAL_BRANCH, OP_CALL, OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN
  } mfps_op_type;

  typedef struct packed {
    logic [7:0] result;
    logic [3:0] status;
  } mfps_alu_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } mfps_reg_req_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
  } mfps_dmem_type;

endpackage

// ### tb/mfps_mem_model.sv
`timescale 1ns/100ps
module mfps_mem_model
  import mfps_pkg::*;
#(
  parameter int PC_W = PC_W_DEFAULT
) (
  input  wire logic               clk,
  input  wire logic [PC_W-1:0]    pmAddr,
  output      logic [INSTR_W-1:0] pmData,
  input  wire mfps_dmem_type      dmem,
  output      logic [7:0]         dmemRdData
);
  // ****************************************
  // program and data storage
  // ****************************************
  logic [INSTR_W-1:0] prog [2**PC_W];
  logic [7:0]         data [256];

  // answers within the cycle after the address moves, so no register here
  assign pmData     = prog[pmAddr];
  assign dmemRdData = data[dmem.addr];

  always @(posedge clk) begin
    if (dmem.wrEn) begin
      data[dmem.addr] <= dmem.wrData;
    end
  end
endmodule

// ### tb/mfps_seq_assertions.sv
`timescale 1ns/100ps
module mfps_seq_assertions
  import mfps_pkg::*;
#(
  parameter int          PC_W         = PC_W_DEFAULT,
  parameter logic [11:0] RESET_VECTOR = RESET_VECTOR_DEF,
  parameter logic [11:0] INT_VECTOR   = INT_VECTOR_DEF
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire mfps_reg_req_type   regReq,
  input wire logic [7:0]         regRdData,
  input wire logic [PC_W-1:0]    pmAddr,
  input wire logic [INSTR_W-1:0] pmData,
  input wire mfps_dmem_type      dmem,
  input wire logic [7:0]         dmemRdData,
  input wire logic               intRequest,
  input wire logic               intAck,
  input wire mfps_phase_type     instructionPhases
);
  // ****************************************
  // helpers and checks
  // ****************************************
  logic afterRst;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      afterRst <= 1'b1;
    end else begin
      afterRst <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_cycle;
    instructionPhases == PH_DECODE ##1 instructionPhases == PH_OPERAND
      ##1 instructionPhases == PH_EXECUTE ##1 instructionPhases == PH_FETCH;
  endsequence

  a_phase_cycle: assert property (instructionPhases == PH_FETCH |=> s_cycle)
    else $error("phase order broken");
  a_fetch_hold: assert property (instructionPhases != PH_FETCH |=> $stable(pmAddr))
    else $error("fetch address moved outside fetch phase");
  a_reset_vector: assert property (afterRst |=> pmAddr == RESET_VECTOR[PC_W-1:0])
    else $error("first fetch not at reset vector");
  a_read_idle: assert property (!regReq.rd |=> regRdData == 8'h00)
    else $error("read data not zero outside answer");
  // a write in the two cycles before would move the counter, so those are left out
  a_pcl_read: assert property (regReq.rd && regReq.addr == REG_PC_LOW_BYTE
    && instructionPhases == PH_OPERAND && !$past(regReq.wr) && !$past(regReq.wr, 2)
    |=> regRdData == pmAddr[7:0] + 8'h01)
    else $error("counter low byte read wrong");
  a_pcl_write: assert property (regReq.wr && regReq.addr == REG_PC_LOW_BYTE
    && instructionPhases == PH_EXECUTE |-> ##2 pmAddr[7:0] == $past(regReq.wrData, 2))
    else $error("low byte write did not steer fetch");
  a_ack_phase: assert property (intAck |-> instructionPhases == PH_FETCH ##1 (!intAck)[*3])
    else $error("acknowledge misplaced");
  a_ack_vector: assert property (intAck |=> pmAddr == INT_VECTOR[PC_W-1:0])
    else $error("acknowledge without vector fetch");
  a_write_pulse: assert property (dmem.wrEn |-> instructionPhases == PH_FETCH
    ##1 (!dmem.wrEn)[*3])
    else $error("data write pulse misplaced");
endmodule

bind mfps_sequencer mfps_seq_assertions #(
  .PC_W(PC_W), .RESET_VECTOR(RESET_VECTOR), .INT_VECTOR(INT_VECTOR)
) i_chk (
  .clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData), .pmAddr(pmAddr),
  .pmData(pmData), .dmem(dmem), .dmemRdData(dmemRdData), .intRequest(intRequest),
  .intAck(intAck), .instructionPhases(instructionPhases)
);

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import mfps_pkg::*;
  // ****************************************
  // harness
  // ****************************************
  logic               clk        = 1'b0;
  logic               nrst       = 1'b0;
  mfps_reg_req_type   regReq     = '0;
  logic               intRequest = 1'b0;
  logic [7:0]         regRdData;
  logic [11:0]        pmAddr;
  logic [INSTR_W-1:0] pmData;
  mfps_dmem_type      dmem;
  logic [7:0]         dmemRdData;
  logic               intAck;
  mfps_phase_type     instructionPhases;
  int                 mismatches = 0;
  int                 n_checks   = 0;
  logic [11:0]        expSeq [16] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h020,
    12'h021, 12'h030, 12'h031, 12'h021, 12'h022, 12'h023, 12'h024, 12'h025, 12'h024, 12'h025};

  always #2 clk = ~clk;

  mfps_sequencer i_dut (.clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
    .pmAddr(pmAddr), .pmData(pmData), .dmem(dmem), .dmemRdData(dmemRdData),
    .intRequest(intRequest), .intAck(intAck), .instructionPhases(instructionPhases));
  mfps_mem_model i_mem (.clk(clk), .pmAddr(pmAddr), .pmData(pmData), .dmem(dmem),
    .dmemRdData(dmemRdData));

  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [19:0] ins(mfps_op_type op, logic [11:0] arg);
    return {op, 3'h0, arg};
  endfunction

  task automatic check(logic [11:0] g, logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // lands at the negedge inside the next cycle of phase p; bounded by eight clocks, two instruction cycles
  task automatic sync(mfps_phase_type p);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (instructionPhases !== p && i < 8);
  endtask

  task automatic fetch(logic [11:0] e);
    sync(PH_DECODE);
    check(pmAddr, e);
  endtask

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic reg_rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    @(negedge clk);
    check({4'h0, regRdData}, {4'h0, e});
  endtask

  task automatic pulse_int;
    @(posedge clk);
    intRequest <= 1'b1;
    @(posedge clk);
    intRequest <= 1'b0;
  endtask

  task automatic wait_ack(int n, logic e);
    logic seen;
    seen = 1'b0;
    repeat (n) if (!seen) begin
      @(negedge clk);
      seen = (intAck === 1'b1);
    end
    check({11'h000, seen}, {11'h000, e});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    for (int a = 0; a < 4096; a++) i_mem.prog[a] = ins(OP_NOP, 12'h000);
    for (int a = 0; a < 256; a++) i_mem.data[a] = 8'h00;
    i_mem.data[8'h10] = 8'h25;
    i_mem.data[8'h11] = 8'hE0;
    i_mem.prog[12'h001] = ins(OP_LDA, 12'h010);
    i_mem.prog[12'h002] = ins(OP_ADD, 12'h011);
    i_mem.prog[12'h003] = ins(OP_UNCONDITIONAL_BRANCH, 12'h020);
    i_mem.prog[12'h004] = ins(OP_INTERRUPT_RETURN, 12'h000);
    i_mem.prog[12'h020] = ins(OP_CALL, 12'h030);
    i_mem.prog[12'h021] = ins(OP_STA, 12'h012);
    i_mem.prog[12'h022] = ins(OP_SZ, 12'h013);
    i_mem.prog[12'h023] = ins(OP_UNCONDITIONAL_BRANCH, 12'h000);
    i_mem.prog[12'h024] = ins(OP_UNCONDITIONAL_BRANCH, 12'h024);
    i_mem.prog[12'h030] = ins(OP_SUBROUTINE_RETURN, 12'h000);
    i_mem.prog[12'h040] = ins(OP_UNCONDITIONAL_BRANCH, 12'h040);
    for (int a = 12'h050; a < 12'h056; a++) i_mem.prog[a] = ins(OP_CALL, 12'(a + 1));
    i_mem.prog[12'h056] = ins(OP_UNCONDITIONAL_BRANCH, 12'h056);
    i_mem.prog[12'h057] = ins(OP_SUBROUTINE_RETURN, 12'h000);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (expSeq[k]) fetch(expSeq[k]);
    reg_rd(REG_ACCUMULATOR, 8'h05);
    reg_wr(REG_STATUS, 8'hFF);
    reg_rd(REG_STATUS, 8'h01);
    check({4'h0, i_mem.data[8'h12]}, 12'h005);
    reg_rd(8'h7F, 8'h00);
    reg_rd(REG_STACK_STATE, 8'h00);
    sync(PH_OPERAND);
    reg_wr(REG_PC_LOW_BYTE, 8'h40);
    fetch(12'h040);
    reg_rd(REG_PC_LOW_BYTE, 8'h41);
    pulse_int();
    wait_ack(16, 1'b1);
    fetch(12'h004);
    reg_rd(REG_PC_LOW_BYTE, 8'h05);
    repeat (3) sync(PH_DECODE);
    sync(PH_OPERAND);
    reg_wr(REG_PC_LOW_BYTE, 8'h50);
    repeat (16) sync(PH_DECODE);
    reg_rd(REG_STACK_STATE, 8'h01);
    pulse_int();
    wait_ack(40, 1'b0);
    reg_rd(REG_STACK_STATE, 8'h05);
    sync(PH_OPERAND);
    reg_wr(REG_PC_LOW_BYTE, 8'h57);
    wait_ack(24, 1'b1);
    // refill the stack with one call, then call once more on a full stack
    repeat (4) sync(PH_DECODE);
    sync(PH_OPERAND);
    reg_wr(REG_PC_LOW_BYTE, 8'h55);
    repeat (4) sync(PH_DECODE);
    sync(PH_OPERAND);
    reg_wr(REG_PC_LOW_BYTE, 8'h55);
    repeat (4) sync(PH_DECODE);
    reg_rd(REG_STACK_STATE, 8'h03);
    reg_wr(REG_STACK_STATE, 8'h02);
    reg_rd(REG_STACK_STATE, 8'h01);
    complete_run();
  end

  // the tests need well under 600 cycles
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
